//--- rxd_decoder.sv
// Receive 8b/10b decoder with APB configuration and interrupt
`timescale 1ns/100ps
`include "rxd_params.svh"
module rxd_decoder
  import rxd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic decode_enable_in,
  input wire logic [79:0] alignedChars,
  output logic [63:0] rx_user_data,
  output logic [15:0] k_char_flags,
  output logic [15:0] disparity_error_flags,
  output logic [7:0] comma_flags,
  output logic [7:0] not_in_table_flags,
  output logic [7:0] seqDispErrFlags,
  output logic irq
);

  localparam rxd_state_t RST_STATE = '{
    wid: `RXD_RST_WID,
    flagP: `RXD_RST_FLAGP,
    flagN: `RXD_RST_FLAGN,
    stdOnly: `RXD_RST_STD,
    seqMatch: `RXD_RST_SEQ,
    mask: `RXD_RST_MASK,
    default: '0
  };

  rxd_state_t s_r;
  rxd_state_t s_nxt;

  // 6b codes at negative disparity, abcdei order, indexed by the 5b value
  localparam logic [31:0][5:0] SIX_NEG = {
    6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27
  };
  function automatic logic [5:0] sixNeg(input logic [4:0] v);
    return SIX_NEG[v];
  endfunction

  // 4b codes at negative disparity, fghj order; alt picks the A7 form
  localparam logic [7:0][3:0] FOUR_NEG = {4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
  function automatic logic [3:0] fourNeg(
    input logic [2:0] v,
    input logic alt
  );
    return (alt && v == 3'h7) ? `RXD_A7_4B : FOUR_NEG[v];
  endfunction

  // One lane: search both disparity columns, keep exact hits first
  function automatic rxd_lane_t decodeChar(
    input logic [9:0] chr,
    input logic rdIn
  );
    logic [9:0] r;
    logic [5:0] s6;
    logic [5:0] n6;
    logic [5:0] p6;
    logic [3:0] s4;
    logic [3:0] c4;
    logic [3:0] e4;
    logic [3:0] o4;
    logic [4:0] x;
    logic [2:0] y;
    logic rd6;
    logic hit6;
    logic err6;
    logic hit4;
    logic err4;
    logic k28;
    logic kAlt;
    logic useA7;
    logic flip;
    rxd_lane_t o;
    for (int i = 0; i < 10; i++) begin
      r[i] = chr[9 - i];
    end
    s6 = r[9:4];
    s4 = r[3:0];
    x = '0;
    y = '0;
    hit6 = 1'b0;
    err6 = 1'b0;
    hit4 = 1'b0;
    err4 = 1'b0;
    kAlt = 1'b0;
    k28 = (s6 == `RXD_K28_6B) || (s6 == ~`RXD_K28_6B);
    if (k28) begin
      x = `RXD_K28;
      hit6 = 1'b1;
      err6 = (s6 != (rdIn ? ~`RXD_K28_6B : `RXD_K28_6B));
    end
    for (int i = 0; i < 32; i++) begin
      n6 = sixNeg(5'(i));
      p6 = ($countones(n6) == 3 && i != 7) ? n6 : ~n6;
      if (!k28 && (s6 == n6 || s6 == p6)) begin
        hit6 = 1'b1;
        x = 5'(i);
        err6 = (s6 != (rdIn ? p6 : n6));
      end
    end
    rd6 = ($countones(s6) > 3) ? 1'b1 : ($countones(s6) < 3) ? 1'b0 : rdIn;
    useA7 = k28 || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
      || (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
    for (int j = 0; j < 8; j++) begin
      c4 = fourNeg(3'(j), useA7);
      flip = ($countones(c4) != 2) || (j == 3);
      e4 = flip ? (rd6 ? ~c4 : c4) : ((k28 && !rd6) ? ~c4 : c4);
      o4 = (flip || k28) ? ~e4 : e4;
      // Exact match beats a wrong-column alias of another code
      if (s4 == e4) begin
        hit4 = 1'b1;
        y = 3'(j);
        err4 = 1'b0;
      end else if (s4 == o4 && !(hit4 && !err4)) begin
        hit4 = 1'b1;
        y = 3'(j);
        err4 = 1'b1;
      end
    end
    // K23/K27/K29/K30 use the alternate 4b code
    if (!hit4 && !k28 && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E)) begin
      e4 = rd6 ? ~`RXD_A7_4B : `RXD_A7_4B;
      if (s4 == e4 || s4 == ~e4) begin
        hit4 = 1'b1;
        y = 3'h7;
        kAlt = 1'b1;
        err4 = (s4 != e4);
      end
    end
    o = '0;
    o.rd = ($countones(s4) > 2) ? 1'b1 : ($countones(s4) < 2) ? 1'b0 : rd6;
    if (hit6 && hit4) begin
      o.data = {y, x};
      o.k = k28 || kAlt;
      o.derr = err6 || err4;
      o.seqErr = err6 || err4;
      o.std = k28 && (y == 3'h1 || y == 3'h5 || y == 3'h7);
      o.pc = (r[9:3] == `RXD_POSITIVE_COMMA);
      o.nc = (r[9:3] == `RXD_NCOMMA);
    end else begin
      o.data = chr[7:0];
      o.k = chr[8];
      o.derr = chr[9];
      o.nit = 1'b1;
    end
    return o;
  endfunction

  // Next state: lanes, register file, events
  always_comb begin
    rxd_lane_t lr;
    logic [9:0] chr;
    logic rdChain;
    logic tenMode;
    logic useDec;
    logic setup;
    logic access;
    logic [3:0] nLanes;
    logic [`RXD_EV_W-1:0] ev;
    logic [`RXD_EV_W-1:0] clr;
    lr = '0;
    chr = '0;
    ev = '0;
    clr = '0;
    nLanes = 4'h8;
    rdChain = s_r.rd;
    tenMode = (s_r.wid == `RXD_W20) || (s_r.wid == `RXD_W40) || (s_r.wid == `RXD_W80);
    // enable sampled every clock; bytes pass at 8-multiples
    useDec = decode_enable_in && tenMode;
    setup = psel && !penable;
    access = psel && penable && s_r.pready;
    s_nxt = s_r;
    // lane count follows the width setting
    unique case (s_r.wid)
      `RXD_W16, `RXD_W20: nLanes = 4'h2;
      `RXD_W32, `RXD_W40: nLanes = 4'h4;
      default: nLanes = 4'h8;
    endcase
    s_nxt.data = '0;
    s_nxt.kf = '0;
    s_nxt.df = '0;
    s_nxt.cf = '0;
    s_nxt.nf = '0;
    s_nxt.sf = '0;
    for (int i = 0; i < 8; i++) begin
      chr = alignedChars[10*i +: 10];
      lr = decodeChar(chr, rdChain);
      if (4'(i) < nLanes) begin
        if (useDec) begin
          // lane i owns byte i and flag bit i
          s_nxt.data[8*i +: 8] = lr.data;
          s_nxt.kf[i] = lr.k;
          s_nxt.df[i] = lr.derr;
          s_nxt.nf[i] = lr.nit;
          s_nxt.cf[i] = !lr.nit && ((lr.pc && s_r.flagP) || (lr.nc && s_r.flagN))
            && (!s_r.stdOnly || lr.std);
          s_nxt.sf[i] = s_r.seqMatch && lr.seqErr;
          rdChain = lr.rd;
        end else if (tenMode) begin
          s_nxt.data[8*i +: 8] = chr[7:0];
          s_nxt.kf[i] = chr[8];
          s_nxt.df[i] = chr[9];
        end else begin
          s_nxt.data[8*i +: 8] = alignedChars[8*i +: 8];
        end
      end
    end
    // last lane's disparity carries to next cycle
    s_nxt.rd = rdChain;
    s_nxt.enSeen = decode_enable_in;
    // Events only in decode mode; raw bit 9 is not an error
    if (useDec) begin
      ev[`RXD_EV_DERR] = |(s_nxt.df & ~s_nxt.nf);
      ev[`RXD_EV_NIT] = |s_nxt.nf;
      ev[`RXD_EV_COMMA] = |s_nxt.cf;
    end
    // APB: answer prepared in setup, so access is zero-wait
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.prdata = '0;
      s_nxt.pslverr = 1'b0;
      case (paddr)
        `RXD_ADDR_CFG: begin
          s_nxt.prdata[`RXD_CFG_WID] = s_r.wid;
          s_nxt.prdata[`RXD_CFG_FLAGP] = s_r.flagP;
          s_nxt.prdata[`RXD_CFG_FLAGN] = s_r.flagN;
          s_nxt.prdata[`RXD_CFG_STD] = s_r.stdOnly;
          s_nxt.prdata[`RXD_CFG_SEQ] = s_r.seqMatch;
        end
        `RXD_ADDR_STAT: s_nxt.prdata[`RXD_EV_W-1:0] = s_r.status;
        `RXD_ADDR_MASK: s_nxt.prdata[`RXD_EV_W-1:0] = s_r.mask;
        `RXD_ADDR_STATE: begin
          s_nxt.prdata[`RXD_ST_RD] = s_r.rd;
          s_nxt.prdata[`RXD_ST_EN] = s_r.enSeen;
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    if (access && pwrite && paddr == `RXD_ADDR_CFG) begin
      s_nxt.wid = pwdata[`RXD_CFG_WID];
      s_nxt.flagP = pwdata[`RXD_CFG_FLAGP];
      s_nxt.flagN = pwdata[`RXD_CFG_FLAGN];
      s_nxt.stdOnly = pwdata[`RXD_CFG_STD];
      s_nxt.seqMatch = pwdata[`RXD_CFG_SEQ];
    end
    if (access && pwrite && paddr == `RXD_ADDR_MASK) begin
      s_nxt.mask = pwdata[`RXD_EV_W-1:0];
    end
    // Clear only what the read returned, so late events survive
    if (access && !pwrite && paddr == `RXD_ADDR_STAT) begin
      clr = s_r.prdata[`RXD_EV_W-1:0];
    end
    s_nxt.status = (s_r.status & ~clr) | ev;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops, upper flags low
  assign rx_user_data = s_r.data;
  assign k_char_flags = {8'h00, s_r.kf};
  assign disparity_error_flags = {8'h00, s_r.df};
  assign comma_flags = s_r.cf;
  assign not_in_table_flags = s_r.nf;
  assign seqDispErrFlags = s_r.sf;
  assign irq = s_r.irq;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // Checks
  sequence SEQ_APB_SETUP;
    psel && !penable;
  endsequence

  sequence SEQ_DEC20;
    decode_enable_in && s_r.wid == `RXD_W20;
  endsequence

  AST_APB_ZERO_WAIT:
    assert property (@(posedge core_clk) disable iff (!resetn)
      SEQ_APB_SETUP |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  AST_LANE_COUNT:
    assert property (@(posedge core_clk) disable iff (!resetn)
      s_r.wid == `RXD_W40 |=> (not_in_table_flags[7:4] == 4'h0
        && comma_flags[7:4] == 4'h0 && k_char_flags[7:4] == 4'h0))
    else $error("flags seen on unused lanes");

  AST_RD_HOLD:
    assert property (@(posedge core_clk) disable iff (!resetn)
      !decode_enable_in |=> s_r.rd == $past(s_r.rd))
    else $error("disparity moved while bypassed");

  AST_BIT_REVERSE:
    assert property (@(posedge core_clk) disable iff (!resetn)
      SEQ_DEC20 ##0 (!s_r.rd && alignedChars[9:0] == `RXD_K285_RAWN)
      |=> (rx_user_data[7:0] == `RXD_BYTE_K285 && k_char_flags[0]
        && !disparity_error_flags[0] && !not_in_table_flags[0]))
    else $error("K28.5 not decoded");

  AST_DATA_LOW:
    assert property (@(posedge core_clk) disable iff (!resetn)
      SEQ_DEC20 |=> rx_user_data[63:16] == 48'h0)
    else $error("data above 16 bits at width 20");

  AST_BYPASS_RAW:
    assert property (@(posedge core_clk) disable iff (!resetn)
      (!decode_enable_in && s_r.wid == `RXD_W20)
      |=> (rx_user_data[7:0] == $past(alignedChars[7:0])
        && k_char_flags[0] == $past(alignedChars[8])
        && disparity_error_flags[0] == $past(alignedChars[9])))
    else $error("raw layout wrong in bypass");

  AST_DISP_ERR:
    assert property (@(posedge core_clk) disable iff (!resetn)
      SEQ_DEC20 ##0 (!s_r.rd && alignedChars[9:0] == `RXD_K285_RAWP)
      |=> (disparity_error_flags[0] && rx_user_data[7:0] == `RXD_BYTE_K285))
    else $error("disparity error missed");

  AST_NIT_RAW:
    assert property (@(posedge core_clk) disable iff (!resetn)
      not_in_table_flags[0] |-> (rx_user_data[7:0] == $past(alignedChars[7:0])
        && !comma_flags[0] && $past(decode_enable_in)))
    else $error("invalid character not passed raw");

  AST_COMMA_GATE:
    assert property (@(posedge core_clk) disable iff (!resetn)
      comma_flags[0] |-> ($past(s_r.flagP || s_r.flagN) && k_char_flags[0]))
    else $error("comma flag while comma flagging off");

  AST_STD_COMMA:
    assert property (@(posedge core_clk) disable iff (!resetn)
      (comma_flags[0] && $past(s_r.stdOnly)) |-> (rx_user_data[7:0] == `RXD_BYTE_K281
        || rx_user_data[7:0] == `RXD_BYTE_K285 || rx_user_data[7:0] == `RXD_BYTE_K287))
    else $error("non-standard comma flagged");

  AST_SEQ_GATE:
    assert property (@(posedge core_clk) disable iff (!resetn)
      (seqDispErrFlags != 8'h00) |-> ($past(s_r.seqMatch)
        && (seqDispErrFlags & ~disparity_error_flags[7:0]) == 8'h00))
    else $error("sequence disparity status leaked");

  AST_IRQ_LEVEL:
    assert property (@(posedge core_clk) disable iff (!resetn)
      irq == |(s_r.status & s_r.mask))
    else $error("interrupt level disagrees with status");

endmodule

//--- rxd_params.svh
// Constants for the receive 8b/10b decoder block
`ifndef RXD_PARAMS_SVH
`define RXD_PARAMS_SVH

// Register byte offsets on the APB slave
`define RXD_ADDR_CFG 8'h00
`define RXD_ADDR_STAT 8'h04
`define RXD_ADDR_MASK 8'h08
`define RXD_ADDR_STATE 8'h0C

// Configuration register fields
`define RXD_CFG_WID 2:0
`define RXD_CFG_FLAGP 4
`define RXD_CFG_FLAGN 5
`define RXD_CFG_STD 6
`define RXD_CFG_SEQ 7

// State register fields
`define RXD_ST_RD 0
`define RXD_ST_EN 1

// Event bits, shared by status and mask
`define RXD_EV_DERR 0
`define RXD_EV_NIT 1
`define RXD_EV_COMMA 2
`define RXD_EV_W 3

// Width setting codes
`define RXD_W16 3'h0
`define RXD_W20 3'h1
`define RXD_W32 3'h2
`define RXD_W40 3'h3
`define RXD_W64 3'h4
`define RXD_W80 3'h5

// Reset values
`define RXD_RST_WID `RXD_W80
`define RXD_RST_FLAGP 1'b1
`define RXD_RST_FLAGN 1'b1
`define RXD_RST_STD 1'b0
`define RXD_RST_SEQ 1'b0
`define RXD_RST_MASK 3'h0

// Code points
`define RXD_K28_6B 6'h0F
`define RXD_K28 5'h1C
`define RXD_A7_4B 4'h7
`define RXD_POSITIVE_COMMA 7'h1F
`define RXD_NCOMMA 7'h60
`define RXD_K285_RAWN 10'h17C
`define RXD_K285_RAWP 10'h283
`define RXD_BYTE_K281 8'h3C
`define RXD_BYTE_K285 8'hBC
`define RXD_BYTE_K287 8'hFC

`endif

//--- rxd_pkg.sv
// Types for the receive 8b/10b decoder block
`include "rxd_params.svh"
package rxd_pkg;

  // Result of decoding one lane
  typedef struct packed {
    logic [7:0] data;
    logic k;
    logic derr;
    logic seqErr;
    logic nit;
    logic pc;
    logic nc;
    logic std;
    logic rd;
  } rxd_lane_t;

  // Whole state of the decoder
  typedef struct packed {
    logic [2:0] wid;
    logic flagP;
    logic flagN;
    logic stdOnly;
    logic seqMatch;
    logic [`RXD_EV_W-1:0] mask;
    logic [`RXD_EV_W-1:0] status;
    logic rd;
    logic enSeen;
    logic [63:0] data;
    logic [7:0] kf;
    logic [7:0] df;
    logic [7:0] cf;
    logic [7:0] nf;
    logic [7:0] sf;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rxd_state_t;

endpackage

//--- rxd_fabric_sink.sv
// Fabric-side consumer model that counts cycles carrying invalid codes
`timescale 1ns/100ps
module rxd_fabric_sink (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] not_in_table_flags,
  output logic [7:0] nitCycles
);
  typedef struct packed {
    logic [7:0] nitCycles;
  } rxd_sink_t;
  rxd_sink_t state_r;
  rxd_sink_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    if (not_in_table_flags != 8'h00) begin
      state_nxt.nitCycles = state_r.nitCycles + 8'h01;
    end
  end
  // Count restarts on reset so a mid-run reset is visible
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign nitCycles = state_r.nitCycles;
endmodule

//--- tb_top.sv
// Self-checking bench for the receive 8b/10b decoder
`timescale 1ns/100ps
`include "rxd_params.svh"
module tb_top;
  typedef struct packed {
    logic [7:0] cfg;
    logic en;
    logic [79:0] ch;
    logic [63:0] dat;
    logic [7:0] k;
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] n;
    logic [7:0] s;
  } rxd_row_t;
  // Characters as received, bit 0 first on the wire
  localparam logic [9:0] CD0 = 10'h0B9;
  localparam logic [9:0] CKP = 10'h17C;
  localparam logic [9:0] CKN = 10'h283;
  localparam logic [9:0] CBAD = 10'h3FF;
  localparam logic [79:0] IDLE = {8{CD0}};
  localparam logic [79:0] RAW = 80'h0123456789ABCDEF1357;
  localparam int NROW = 13;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic decode_enable_in = 1'b1;
  logic [79:0] alignedChars = IDLE;
  logic [63:0] rx_user_data;
  logic [15:0] k_char_flags;
  logic [15:0] disparity_error_flags;
  logic [7:0] comma_flags;
  logic [7:0] not_in_table_flags;
  logic [7:0] seqDispErrFlags;
  logic irq;
  logic [7:0] nitCycles;
  logic [31:0] rdv;
  logic er;
  int bad_count = 0;
  int compares = 0;
  rxd_row_t rows [NROW];

  rxd_decoder i_dut (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .decode_enable_in(decode_enable_in), .alignedChars(alignedChars),
    .rx_user_data(rx_user_data), .k_char_flags(k_char_flags),
    .disparity_error_flags(disparity_error_flags), .comma_flags(comma_flags),
    .not_in_table_flags(not_in_table_flags), .seqDispErrFlags(seqDispErrFlags), .irq(irq));
  rxd_fabric_sink i_sink (.core_clk(core_clk), .resetn(resetn),
    .not_in_table_flags(not_in_table_flags), .nitCycles(nitCycles));

  // Free-running 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // APB master; waits on pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) begin
      chk(1'b0, 1'b1, "apb wait");
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk(v, exp, "read data");
    chk(e, expErr, "read error");
  endtask

  task automatic step(input logic en, input logic [79:0] ch);
    @(posedge core_clk);
    decode_enable_in <= en;
    alignedChars <= ch;
  endtask

  task automatic chk_row(input rxd_row_t r);
    chk(rx_user_data, r.dat, "data");
    chk(k_char_flags, {8'h00, r.k}, "k flags");
    chk(disparity_error_flags, {8'h00, r.d}, "disp flags");
    chk(comma_flags, r.c, "comma flags");
    chk(not_in_table_flags, r.n, "nit flags");
    chk(seqDispErrFlags, r.s, "seq flags");
  endtask

  // Hang guard, far beyond the roughly 130 cycles needed
  initial begin
    repeat (4000) @(posedge core_clk);
    bad_count++;
    test_done();
  end

  initial begin
    // Decoding rows: cfg, enable, characters, then expected outputs
    rows[0] = '{8'h31, 1'b1, {{6{CD0}}, CKN, CKP}, 64'hBCBC, 8'h03, 0, 8'h03, 0, 0};
    rows[1] = '{8'h21, 1'b1, {{6{CD0}}, CKN, CKP}, 64'hBCBC, 8'h03, 0, 8'h02, 0, 0};
    rows[2] = '{8'h11, 1'b1, {{6{CD0}}, CKN, CKP}, 64'hBCBC, 8'h03, 0, 8'h01, 0, 0};
    rows[3] = '{8'h75, 1'b1, {{6{CD0}}, CKN, CKP}, 64'hBCBC, 8'h03, 0, 8'h03, 0, 0};
    rows[4] = '{8'h11, 1'b1, {{7{CD0}}, CKN}, 64'hBC, 8'h01, 8'h01, 0, 0, 0};
    rows[5] = '{8'h95, 1'b1, {{6{CD0}}, CKN, CD0}, 64'hBC00, 8'h02, 8'h02, 0, 0, 8'h02};
    rows[6] = '{8'h33, 1'b1, {{4{CKP}}, CD0, CD0, CKN, CBAD}, 64'hBCFF, 8'h03, 8'h01,
                8'h02, 8'h01, 0};
    // Bypass rows at ten- and eight-multiple widths, then one decoding row at width 80
    rows[7] = '{8'h31, 1'b0, {{5{10'h000}}, CBAD, 10'h25A, 10'h1A5}, 64'h5AA5, 8'h01,
                8'h02, 0, 0, 0};
    rows[8] = '{8'h33, 1'b0, {{4{CBAD}}, 10'h0F0, CBAD, 10'h25A, 10'h1A5}, 64'hF0FF5AA5,
                8'h05, 8'h06, 0, 0, 0};
    rows[9] = '{8'h30, 1'b0, RAW, 64'h1357, 0, 0, 0, 0, 0};
    rows[10] = '{8'h32, 1'b0, RAW, 64'hCDEF1357, 0, 0, 0, 0, 0};
    rows[11] = '{8'h34, 1'b0, RAW, 64'h456789ABCDEF1357, 0, 0, 0, 0, 0};
    rows[12] = '{8'h35, 1'b1, {4{CKN, CKP}}, 64'hBCBCBCBCBCBCBCBC, 8'hFF, 0, 8'hFF, 0, 0};
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(`RXD_ADDR_CFG, 32'h35, 1'b0);
    rchk(`RXD_ADDR_MASK, 32'h0, 1'b0);
    rchk(`RXD_ADDR_STAT, 32'h0, 1'b0);
    rchk(`RXD_ADDR_STATE, 32'h2, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < NROW; i++) begin
      apb(1'b1, `RXD_ADDR_CFG, {24'h0, rows[i].cfg}, rdv, er);
      step(rows[i].en, rows[i].ch);
      step(1'b1, IDLE);
      #1;
      chk_row(rows[i]);
    end
    $display("test row table done");
    // Sticky status, masking and the interrupt level
    chk(irq, 1'b0, "irq masked");
    rchk(`RXD_ADDR_STAT, 32'h7, 1'b0);
    rchk(`RXD_ADDR_STAT, 32'h0, 1'b0);
    apb(1'b1, `RXD_ADDR_MASK, 32'h4, rdv, er);
    step(1'b1, {{6{CD0}}, CKN, CKP});
    step(1'b1, IDLE);
    repeat (2) @(posedge core_clk);
    #1;
    chk(irq, 1'b1, "irq raised");
    rchk(`RXD_ADDR_STAT, 32'h4, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    chk(irq, 1'b0, "irq cleared");
    $display("test interrupt done");
    // Disparity carried from the last lane into the next cycle
    step(1'b1, {CKP, {7{CD0}}});
    step(1'b1, {{7{CD0}}, CKN});
    #1;
    chk(rx_user_data, 64'hBC00000000000000, "carry data a");
    chk(k_char_flags, 16'h0080, "carry k a");
    step(1'b1, IDLE);
    #1;
    chk(rx_user_data, 64'hBC, "carry data b");
    chk(disparity_error_flags, 16'h0000, "carry disp b");
    chk(nitCycles, 8'h01, "sink nit count");
    $display("test disparity carry done");
    // Unmapped offset, ignored status write, state readback
    rchk(8'h10, 32'h0, 1'b1);
    apb(1'b1, `RXD_ADDR_STAT, 32'h7, rdv, er);
    chk(er, 1'b0, "status write error");
    rchk(`RXD_ADDR_STAT, 32'h4, 1'b0);
    rchk(`RXD_ADDR_STAT, 32'h0, 1'b0);
    rchk(`RXD_ADDR_STATE, 32'h2, 1'b0);
    $display("test register access done");
    // Second reset in mid-run restores defaults
    apb(1'b1, `RXD_ADDR_CFG, 32'h31, rdv, er);
    step(1'b1, {{6{CD0}}, CKN, CKP});
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(rx_user_data, 64'h0, "data in reset");
    chk(k_char_flags, 16'h0, "k in reset");
    @(posedge core_clk);
    resetn <= 1'b1;
    rchk(`RXD_ADDR_CFG, 32'h35, 1'b0);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
